// file: logic/rmhs_defs.svh
// Bit positions, register offsets and reset values of the remote handshake block
`ifndef RMHS_DEFS_SVH
`define RMHS_DEFS_SVH

// ----------------------------------------
// Status word bit positions
// ----------------------------------------
`define RMHS_ST_INIT_REQ   8
`define RMHS_ST_CHG_ACK    9
`define RMHS_ST_ERR_FLAG   10
`define RMHS_ST_READY      11
`define RMHS_ST_WARN_FLAG  12

// ----------------------------------------
// Operation word bit positions
// ----------------------------------------
`define RMHS_OP_INIT_DONE  8
`define RMHS_OP_CHG_REQ    9
`define RMHS_OP_ERR_CLR    10

// ----------------------------------------
// Controller register offsets (byte addresses)
// ----------------------------------------
`define RMHS_ADDR_CTRL     8'h00
`define RMHS_ADDR_STATUS   8'h04
`define RMHS_ADDR_ERRCODE  8'h08
`define RMHS_ADDR_WARNCODE 8'h0c
`define RMHS_ADDR_SETTING  8'h10

// ----------------------------------------
// Controller control register fields
// ----------------------------------------
`define RMHS_CTRL_INIT_DONE 0
`define RMHS_CTRL_CHG_REQ   1
`define RMHS_CTRL_ERR_CLR   2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RMHS_WORD_RST      16'h0000
`define RMHS_CODE_CLEAR    16'h0000

`endif

// file: logic/rmhs_device.sv
// Remote module end: start-up handshake, setting change, error and warning flags
//
// What this block does
// - Status word bits eight to twelve defined
// - Operation word bits eight to ten defined
// - With-init mode raises init request until done
// - Init done completes start-up, raises ready
// - Init done drops the init request
// - Without-init mode: no request, ready after start
// - Without-init mode loads stored parameters first
// - Setting request applies data, then acknowledges
// - Setting request clears warning code and flag
// - Setting request clears error if cause gone
// - Setting request drops remote ready
// - Moderate or major error sets error flag
// - Latest non-watchdog error code is stored
// - Error clear with cause gone clears error
// - Clear during cause: flag stays set
// - Major error ignores every clear request
// - Early release of clear leaves flag set
// - One clear request covers all channels
// - Minor error sets warning flag and code
// - Warning self-clears once its cause goes
// - Master takes setting data and change request only while ready
`timescale 1ns/1ps
`include "rmhs_defs.svh"

module rmhs_device #(
    parameter int CHANNELS = 8  // Number of field channels
) (
    input  wire logic                 core_clk,        // System clock
    input  wire logic                 reset_n,         // Asynchronous reset, active low
    rmhs_if.device                    link,            // Remote register link
    input  wire logic                 withInitMode,    // Start-up mode: 1 with initial processing
    output      logic                 nvLoadStart,     // Pulse: read stored parameters
    input  wire logic                 nvLoadDone,      // Pulse: stored parameters valid
    input  wire rmhs_pkg::rmhs_word_t nvData,          // Stored parameter word
    output      rmhs_pkg::rmhs_word_t activeSetting,   // Setting in force
    output      logic                 ioUpdateEn,      // External I/O updating enabled
    input  wire logic                 errEvent,        // Pulse: moderate or major error
    input  wire logic                 errEventMajor,   // Error with the pulse is major
    input  wire logic                 errEventWdt,     // Error with the pulse is watchdog
    input  wire rmhs_pkg::rmhs_word_t errEventCode,    // Code of the error
    input  wire logic [CHANNELS-1:0]  errCause,        // Moderate causes still present per channel
    input  wire logic                 warnEvent,       // Pulse: minor error
    input  wire rmhs_pkg::rmhs_word_t warnEventCode,   // Code of the minor error
    input  wire logic [CHANNELS-1:0]  warnCause        // Minor causes still present per channel
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    rmhs_pkg::rmhs_state_e state_reg;      // Sequencer state
    rmhs_pkg::rmhs_state_e state_next;     // Next sequencer state
    logic                  errFlag_reg;    // Error flag
    logic                  errFlag_next;   // Next error flag
    rmhs_pkg::rmhs_word_t  errCode_reg;    // Latest error code
    rmhs_pkg::rmhs_word_t  errCode_next;   // Next error code
    logic                  warnFlag_reg;   // Warning flag
    logic                  warnFlag_next;  // Next warning flag
    rmhs_pkg::rmhs_word_t  warnCode_reg;   // Latest warning code
    rmhs_pkg::rmhs_word_t  warnCode_next;  // Next warning code
    logic                  major_reg;      // Sticky major or watchdog error
    logic                  chgReqOld_reg;  // Request seen last cycle
    logic                  initDone;       // Init done bit from master
    logic                  chgReq;         // Setting change request bit
    logic                  errClr;         // Error clear request bit
    logic                  chgRise;        // First cycle of a change request
    logic                  errCauseAny;    // Any channel still in moderate error
    logic                  errClearOk;     // Clear may act now

    // ----------------------------------------
    // Operation word decode
    // ----------------------------------------
    assign initDone    = link.opWord[`RMHS_OP_INIT_DONE];
    assign chgReq      = link.opWord[`RMHS_OP_CHG_REQ];
    assign errClr      = link.opWord[`RMHS_OP_ERR_CLR];
    assign chgRise     = chgReq & ~chgReqOld_reg;
    assign errCauseAny = |errCause;
    assign errClearOk  = ~major_reg & ~errCauseAny;

    // ----------------------------------------
    // Status word assembly
    // ----------------------------------------
    // Reserved bits read as zero
    always_comb begin
        link.statusWord = `RMHS_WORD_RST;
        link.statusWord[`RMHS_ST_INIT_REQ]  = (state_reg == rmhs_pkg::RMHS_INIT_REQ);
        link.statusWord[`RMHS_ST_CHG_ACK]   = (state_reg == rmhs_pkg::RMHS_ACK);
        link.statusWord[`RMHS_ST_ERR_FLAG]  = errFlag_reg;
        link.statusWord[`RMHS_ST_READY]     = (state_reg == rmhs_pkg::RMHS_RUN);
        link.statusWord[`RMHS_ST_WARN_FLAG] = warnFlag_reg;
    end

    assign link.errCodeWord  = errCode_reg;
    assign link.warnCodeWord = warnCode_reg;

    // I/O updates once start-up is over
    assign ioUpdateEn = (state_reg == rmhs_pkg::RMHS_RUN) || (state_reg == rmhs_pkg::RMHS_APPLY)
                        || (state_reg == rmhs_pkg::RMHS_ACK);

    // ----------------------------------------
    // Sequencer next state
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rmhs_pkg::RMHS_START: begin
                // Choose path from the start-up mode
                if (withInitMode) begin
                    state_next = rmhs_pkg::RMHS_INIT_REQ;
                end else begin
                    state_next = rmhs_pkg::RMHS_NV_LOAD;
                end
            end
            rmhs_pkg::RMHS_NV_LOAD: begin
                // Stored parameters arrive, then run
                if (nvLoadDone) begin
                    state_next = rmhs_pkg::RMHS_RUN;
                end
            end
            rmhs_pkg::RMHS_INIT_REQ: begin
                // Hold request until master reports done
                if (initDone) begin
                    state_next = rmhs_pkg::RMHS_RUN;
                end
            end
            rmhs_pkg::RMHS_RUN: begin
                // Request drops ready on the next clock edge
                if (chgReq) begin
                    state_next = rmhs_pkg::RMHS_APPLY;
                end
            end
            rmhs_pkg::RMHS_APPLY: begin
                // Settings taken this cycle
                state_next = rmhs_pkg::RMHS_ACK;
            end
            rmhs_pkg::RMHS_ACK: begin
                // Acknowledge stands until release
                if (!chgReq) begin
                    state_next = rmhs_pkg::RMHS_RUN;
                end
            end
            default: begin
                state_next = rmhs_pkg::RMHS_START;
            end
        endcase
    end

    // ----------------------------------------
    // Sequencer state register
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= rmhs_pkg::RMHS_START;
        end else begin
            state_reg <= state_next;
        end
    end

    // Stored-parameter read pulse on entry
    assign nvLoadStart = (state_reg == rmhs_pkg::RMHS_START) && !withInitMode;

    // ----------------------------------------
    // Active setting
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            activeSetting <= `RMHS_WORD_RST;
        end else if (state_reg == rmhs_pkg::RMHS_NV_LOAD && nvLoadDone) begin
            activeSetting <= nvData;
        end else if (state_reg == rmhs_pkg::RMHS_APPLY) begin
            activeSetting <= link.settingWord;
        end
    end

    // ----------------------------------------
    // Request edge history
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            chgReqOld_reg <= 1'b0;
        end else begin
            chgReqOld_reg <= chgReq;
        end
    end

    // ----------------------------------------
    // Sticky major error, only reset clears it
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            major_reg <= 1'b0;
        end else if (errEvent && (errEventMajor || errEventWdt)) begin
            major_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // Error flag and code next values
    // ----------------------------------------
    // New event wins over any clear
    always_comb begin
        errFlag_next = errFlag_reg;
        errCode_next = errCode_reg;
        if (errEvent) begin
            errFlag_next = 1'b1;
            if (!errEventWdt) begin
                errCode_next = errEventCode;
            end
        end else if (chgRise && errClearOk) begin
            errFlag_next = 1'b0;
            errCode_next = `RMHS_CODE_CLEAR;
        end else if (errClr && !major_reg) begin
            // Flag held while any cause stays
            errFlag_next = errCauseAny;
            if (!errCauseAny) begin
                errCode_next = `RMHS_CODE_CLEAR;
            end
        end
    end

    // ----------------------------------------
    // Error registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            errFlag_reg <= 1'b0;
            errCode_reg <= `RMHS_CODE_CLEAR;
        end else begin
            errFlag_reg <= errFlag_next;
            errCode_reg <= errCode_next;
        end
    end

    // ----------------------------------------
    // Warning flag and code next values
    // ----------------------------------------
    always_comb begin
        warnFlag_next = warnFlag_reg;
        warnCode_next = warnCode_reg;
        if (warnEvent) begin
            warnFlag_next = 1'b1;
            warnCode_next = warnEventCode;
        end else if (chgRise || !(|warnCause)) begin
            warnFlag_next = 1'b0;
            warnCode_next = `RMHS_CODE_CLEAR;
        end
    end

    // ----------------------------------------
    // Warning registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            warnFlag_reg <= 1'b0;
            warnCode_reg <= `RMHS_CODE_CLEAR;
        end else begin
            warnFlag_reg <= warnFlag_next;
            warnCode_reg <= warnCode_next;
        end
    end

endmodule

// file: logic/rmhs_if.sv
// Remote register link between the master controller and the remote module
`timescale 1ns/1ps

interface rmhs_if;
    rmhs_pkg::rmhs_word_t opWord;       // Operation word, master to device
    rmhs_pkg::rmhs_word_t settingWord;  // New setting data, master to device
    rmhs_pkg::rmhs_word_t statusWord;   // Status word, device to master
    rmhs_pkg::rmhs_word_t errCodeWord;  // Latest error code
    rmhs_pkg::rmhs_word_t warnCodeWord; // Latest warning code

    // Remote module end
    modport device (
        input  opWord,
        input  settingWord,
        output statusWord,
        output errCodeWord,
        output warnCodeWord
    );

    // Master station end
    modport master (
        output opWord,
        output settingWord,
        input  statusWord,
        input  errCodeWord,
        input  warnCodeWord
    );
endinterface

// file: logic/rmhs_master.sv
// Master station end: drives the operation word from software registers
`timescale 1ns/1ps
`include "rmhs_defs.svh"

module rmhs_master (
    input  wire logic                 core_clk,  // System clock
    input  wire logic                 reset_n,   // Asynchronous reset, active low
    rmhs_if.master                    link,      // Remote register link
    input  wire logic [7:0]           addr,      // Register byte address
    input  wire logic [31:0]          wrData,    // Write data
    input  wire logic                 wrStb,     // Write strobe
    input  wire logic                 rdStb,     // Read strobe
    output      logic [31:0]          rdData     // Read data, cycle after strobe
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic                 initDone_reg;  // Init done bit
    logic                 chgReq_reg;    // Setting change request bit
    logic                 errClr_reg;    // Error clear request bit
    rmhs_pkg::rmhs_word_t setting_reg;   // Setting data to send
    logic                 ready;         // Remote ready from device
    logic                 ctrlWr;        // Control register write

    assign ready  = link.statusWord[`RMHS_ST_READY];
    assign ctrlWr = wrStb && (addr == `RMHS_ADDR_CTRL);

    // ----------------------------------------
    // Operation word, unused bits left zero
    // ----------------------------------------
    always_comb begin
        link.opWord = `RMHS_WORD_RST;
        link.opWord[`RMHS_OP_INIT_DONE] = initDone_reg;
        link.opWord[`RMHS_OP_CHG_REQ]   = chgReq_reg;
        link.opWord[`RMHS_OP_ERR_CLR]   = errClr_reg;
    end

    assign link.settingWord = setting_reg;

    // ----------------------------------------
    // Init done bit, software owned
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            initDone_reg <= 1'b0;
        end else if (ctrlWr) begin
            initDone_reg <= wrData[`RMHS_CTRL_INIT_DONE];
        end
    end

    // ----------------------------------------
    // Change request, released on acknowledge
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            chgReq_reg <= 1'b0;
        end else if (chgReq_reg && link.statusWord[`RMHS_ST_CHG_ACK]) begin
            chgReq_reg <= 1'b0;
        end else if (ctrlWr && ready) begin
            chgReq_reg <= wrData[`RMHS_CTRL_CHG_REQ];
        end
    end

    // ----------------------------------------
    // Error clear, held until the flag drops
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            errClr_reg <= 1'b0;
        end else if (ctrlWr && wrData[`RMHS_CTRL_ERR_CLR]) begin
            errClr_reg <= 1'b1;
        end else if (!link.statusWord[`RMHS_ST_ERR_FLAG]) begin
            errClr_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Setting data, accepted only while ready
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            setting_reg <= `RMHS_WORD_RST;
        end else if (wrStb && (addr == `RMHS_ADDR_SETTING) && ready) begin
            setting_reg <= wrData[15:0];
        end
    end

    // ----------------------------------------
    // Read port, unmapped reads zero
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= 32'h0000_0000;
        end else if (rdStb) begin
            case (addr)
                `RMHS_ADDR_CTRL:     rdData <= {29'h0, errClr_reg, chgReq_reg, initDone_reg};
                `RMHS_ADDR_STATUS:   rdData <= {16'h0000, link.statusWord};
                `RMHS_ADDR_ERRCODE:  rdData <= {16'h0000, link.errCodeWord};
                `RMHS_ADDR_WARNCODE: rdData <= {16'h0000, link.warnCodeWord};
                `RMHS_ADDR_SETTING:  rdData <= {16'h0000, setting_reg};
                default:             rdData <= 32'h0000_0000;
            endcase
        end else begin
            rdData <= 32'h0000_0000;
        end
    end

endmodule

// file: logic/rmhs_pkg.sv
// Types shared by both ends of the remote handshake block
package rmhs_pkg;

    // ----------------------------------------
    // Remote register word
    // ----------------------------------------
    typedef logic [15:0] rmhs_word_t;

    // ----------------------------------------
    // Device sequencing states
    // ----------------------------------------
    typedef enum logic [2:0] {
        RMHS_START    = 3'b000,  // Decide start-up path
        RMHS_NV_LOAD  = 3'b001,  // Reading stored parameters
        RMHS_INIT_REQ = 3'b010,  // Waiting for init done
        RMHS_RUN      = 3'b011,  // Operating, ready
        RMHS_APPLY    = 3'b100,  // Taking new settings
        RMHS_ACK      = 3'b101   // Acknowledge until request drops
    } rmhs_state_e;

endpackage

// file: test/remote_module_handshake_status_test.sv
// Self-checking bench for both ends of the remote handshake link
`timescale 1ns/1ps
`include "rmhs_defs.svh"
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin badCount++; $display("Error %s expected %h seen %h", nm, ex, got); end end

module remote_module_handshake_status_test;
    // ----------------------------------------
    // Bench signals
    // ----------------------------------------
    logic                 core_clk      = 1'h0;    // System clock
    logic                 reset_n       = 1'h0;    // Reset, active low
    logic [7:0]           addr          = 8'h00;   // Register address
    logic [31:0]          wrData        = 32'h0;   // Write data
    logic                 wrStb         = 1'h0;    // Write strobe
    logic                 rdStb         = 1'h0;    // Read strobe
    logic [31:0]          rdData;                  // Read data
    logic                 withInitMode  = 1'h1;    // Start-up mode
    logic                 nvLoadStart;             // Stored read pulse
    logic                 nvLoadDone    = 1'h0;    // Stored data valid
    rmhs_pkg::rmhs_word_t activeSetting;           // Setting in force
    logic                 ioUpdateEn;              // I/O updating on
    logic                 errEvent      = 1'h0;    // Error pulse
    logic                 errEventWdt   = 1'h0;    // Watchdog, also major
    rmhs_pkg::rmhs_word_t eventCode     = 16'h0;   // Code of either event
    logic [7:0]           errCause      = 8'h00;   // Moderate causes
    logic                 warnEvent     = 1'h0;    // Minor error pulse
    logic [7:0]           warnCause     = 8'h00;   // Minor causes
    int                   badCount      = 0;       // Mismatches
    int                   nTests        = 0;       // Comparisons
    int                   cycles        = 0;       // Timeout counter
    localparam logic [7:0] ASt = `RMHS_ADDR_STATUS, AErr = `RMHS_ADDR_ERRCODE, AWarn = `RMHS_ADDR_WARNCODE;

    // ----------------------------------------
    // Both ends facing each other
    // ----------------------------------------
    rmhs_if rmhs_if_inst ();
    rmhs_master rmhs_master_inst (.core_clk(core_clk), .reset_n(reset_n), .link(rmhs_if_inst.master), .addr(addr),
        .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));
    rmhs_device rmhs_device_inst (.core_clk(core_clk), .reset_n(reset_n), .link(rmhs_if_inst.device),
        .withInitMode(withInitMode), .nvLoadStart(nvLoadStart), .nvLoadDone(nvLoadDone), .nvData(16'h4321),
        .activeSetting(activeSetting), .ioUpdateEn(ioUpdateEn), .errEvent(errEvent), .errEventMajor(errEventWdt),
        .errEventWdt(errEventWdt), .errEventCode(eventCode), .errCause(errCause), .warnEvent(warnEvent),
        .warnEventCode(eventCode), .warnCause(warnCause));
    rmhs_link_chk rmhs_link_chk_inst (.core_clk(core_clk), .reset_n(reset_n), .opWord(rmhs_if_inst.opWord),
        .statusWord(rmhs_if_inst.statusWord), .errCodeWord(rmhs_if_inst.errCodeWord),
        .warnCodeWord(rmhs_if_inst.warnCodeWord));

    // Clock and hang guard
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            badCount++;
            conclude();
        end
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr   <= a;
        wrData <= d;
        wrStb  <= 1'h1;
        @(posedge core_clk);
        wrStb  <= 1'h0;
    endtask

    // Read one register, data taken in the cycle after the strobe
    task automatic rdChk(input logic [7:0] a, input rmhs_pkg::rmhs_word_t ex, input string nm);
        @(posedge core_clk);
        addr  <= a;
        rdStb <= 1'h1;
        @(posedge core_clk);
        rdStb <= 1'h0;
        #1;
        `CHK(nm, {16'h0000, ex}, rdData)
    endtask

    // One-cycle error or warning pulse
    task automatic fire(input logic warn, input logic wdt, input rmhs_pkg::rmhs_word_t code);
        @(posedge core_clk);
        warnEvent   <= warn;
        errEvent    <= !warn;
        errEventWdt <= wdt;
        eventCode   <= code;
        @(posedge core_clk);
        warnEvent <= 1'h0;
        errEvent  <= 1'h0;
    endtask

    task automatic doReset(input logic mode);
        reset_n      <= 1'h0;
        withInitMode <= mode;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'h1;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        doReset(1'h1);
        rdChk(ASt, 16'h0100, "status init");
        wr(`RMHS_ADDR_CTRL, 32'h1);
        rdChk(ASt, 16'h0800, "status ready");
        `CHK("io update", 1'h1, ioUpdateEn)
        $display("Test init handshake done");
        @(posedge core_clk);
        warnCause <= 8'h04;
        fire(1'h1, 1'h0, 16'h00a5);
        rdChk(ASt, 16'h1800, "status warn");
        rdChk(AWarn, 16'h00a5, "warn code");
        wr(`RMHS_ADDR_SETTING, 32'h1234);
        wr(`RMHS_ADDR_CTRL, 32'h3);
        repeat (8) @(posedge core_clk);
        rdChk(ASt, 16'h0800, "status changed");
        rdChk(AWarn, 16'h0000, "warn code changed");
        `CHK("setting", 16'h1234, activeSetting)
        $display("Test condition change done");
        fire(1'h1, 1'h0, 16'h0033);
        rdChk(ASt, 16'h1800, "status warn again");
        @(posedge core_clk);
        warnCause <= 8'h00;
        repeat (2) @(posedge core_clk);
        rdChk(ASt, 16'h0800, "status warn gone");
        rdChk(AWarn, 16'h0000, "warn code gone");
        $display("Test warning done");
        @(posedge core_clk);
        errCause <= 8'h81;
        fire(1'h0, 1'h0, 16'h0201);
        fire(1'h0, 1'h0, 16'h0202);
        rdChk(ASt, 16'h0c00, "status error");
        rdChk(AErr, 16'h0202, "error code");
        wr(`RMHS_ADDR_CTRL, 32'h5);
        repeat (3) @(posedge core_clk);
        rdChk(ASt, 16'h0c00, "error with cause");
        @(posedge core_clk);
        errCause <= 8'h00;
        repeat (3) @(posedge core_clk);
        rdChk(ASt, 16'h0800, "error cleared");
        rdChk(AErr, 16'h0000, "error code cleared");
        `CHK("clear released", 1'h0, rmhs_if_inst.opWord[10])
        fire(1'h0, 1'h0, 16'h0303);
        wr(`RMHS_ADDR_CTRL, 32'h3);
        repeat (8) @(posedge core_clk);
        rdChk(ASt, 16'h0800, "error cleared by change");
        rdChk(AErr, 16'h0000, "code cleared by change");
        fire(1'h0, 1'h1, 16'h0bad);
        wr(`RMHS_ADDR_CTRL, 32'h5);
        repeat (4) @(posedge core_clk);
        rdChk(ASt, 16'h0c00, "major error kept");
        rdChk(AErr, 16'h0000, "watchdog code");
        rdChk(8'h20, 16'h0000, "unmapped read");
        $display("Test errors done");
        @(posedge core_clk);
        doReset(1'h0);
        #1 `CHK("nv start", 1'h1, nvLoadStart)
        rdChk(ASt, 16'h0000, "status loading");
        wr(`RMHS_ADDR_SETTING, 32'h5555);
        rdChk(`RMHS_ADDR_SETTING, 16'h0000, "setting refused");
        @(posedge core_clk);
        nvLoadDone <= 1'h1;
        @(posedge core_clk);
        nvLoadDone <= 1'h0;
        rdChk(ASt, 16'h0800, "status no init");
        `CHK("nv setting", 16'h4321, activeSetting)
        `CHK("io update no init", 1'h1, ioUpdateEn)
        $display("Test start without init done");
        conclude();
    end
endmodule

// file: test/rmhs_link_chk.sv
// Assertions watching the remote register link between both ends
`timescale 1ns/1ps

module rmhs_link_chk (
    input wire logic                 core_clk,     // System clock
    input wire logic                 reset_n,      // Reset, active low
    input wire rmhs_pkg::rmhs_word_t opWord,       // Operation word
    input wire rmhs_pkg::rmhs_word_t statusWord,   // Status word
    input wire rmhs_pkg::rmhs_word_t errCodeWord,  // Error code
    input wire rmhs_pkg::rmhs_word_t warnCodeWord  // Warning code
);
    // ----------------------------------------
    // Link relations
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_status_reserved: assert property (statusWord[7:0] == 8'h00 && statusWord[15:13] == 3'h0)
        else $error("status word reserved bit set");
    a_op_unused: assert property (opWord[7:0] == 8'h00 && opWord[15:11] == 5'h00)
        else $error("operation word unused bit set");
    a_init_hold: assert property (statusWord[8] && !opWord[8] |=> statusWord[8])
        else $error("init request dropped early");
    a_init_done_ready: assert property (statusWord[8] && opWord[8] |=> !statusWord[8] && statusWord[11])
        else $error("init done not answered");
    a_change_drops_ready: assert property ($rose(opWord[9]) |=> !statusWord[11])
        else $error("ready kept during change");
    a_change_ack: assert property ($rose(opWord[9]) |-> ##[1:3] statusWord[9])
        else $error("change not acknowledged");
    a_change_warn_clear: assert property ($rose(opWord[9]) |=> !statusWord[12] && warnCodeWord == 16'h0000)
        else $error("warning kept over change");
    a_ack_not_ready: assert property (statusWord[9] |-> !statusWord[11])
        else $error("ready during acknowledge");
    a_ack_release: assert property (statusWord[9] && !opWord[9] |=> !statusWord[9] && statusWord[11])
        else $error("acknowledge not released");
    a_err_code_flag: assert property (errCodeWord != 16'h0000 |-> statusWord[10])
        else $error("error code without flag");

    // Main scenarios reached
    cover property ($fell(statusWord[8]));
    cover property (statusWord[9]);
    cover property ($rose(statusWord[10]));
    cover property ($fell(statusWord[12]));
endmodule
